// ==== logic/cycle_decode_pkg.sv ====
// Package: opcode fields, addressing modes, timing tables for the cycle decoder
package cycle_decode_pkg;
    // Addressing modes after decode
    typedef enum logic [2:0] {
        AM_REG, AM_IND, AM_AUTOINC, AM_IMM, AM_INDEXED, AM_SYMBOLIC, AM_ABSOLUTE
    } addr_mode_e;

    // Instruction classes
    typedef enum logic [2:0] {
        IC_SINGLE, IC_PUSH, IC_CALL, IC_JUMP, IC_DOUBLE, IC_EXT_WORD, IC_OTHER
    } instr_class_e;

    // Operand sizes
    typedef enum logic [1:0] {
        SZ_RESERVED, SZ_ADDR20, SZ_WORD16, SZ_BYTE8
    } op_size_e;

    // Extension word decode
    localparam logic [4:0] EXT_OPCODE = 5'h03;
    localparam int EXT_OP_HI = 15;
    localparam int EXT_OP_LO = 11;
    localparam int EXT_CARRY_ZERO_BIT = 8;
    localparam int EXT_REP_BIT = 7;
    localparam int EXT_AL_BIT = 6;
    localparam int EXT_CNT_HI = 3;
    localparam int EXT_SRC_HI = 10;
    localparam int EXT_SRC_LO = 7;

    // Format fields of the following instruction
    localparam int BW_BIT = 6;
    localparam int AD_BIT = 7;
    localparam int AS_HI = 5;
    localparam int AS_LO = 4;
    localparam int SREG_HI = 11;
    localparam int SREG_LO = 8;
    localparam int DREG_HI = 3;
    localparam int DREG_LO = 0;
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;
    localparam logic [1:0] AS_REG = 2'h0;
    localparam logic [1:0] AS_IDX = 2'h1;
    localparam logic [1:0] AS_IND = 2'h2;
    localparam logic [1:0] AS_INC = 2'h3;

    // Opcode groups
    localparam logic [5:0] SINGLE_PREFIX = 6'h04;
    localparam logic [2:0] JUMP_PREFIX = 3'h1;
    localparam logic [2:0] OP2_PUSH = 3'h4;
    localparam logic [2:0] OP2_CALL = 3'h5;
    localparam logic [3:0] OPC_MOV = 4'h4;
    localparam logic [3:0] OPC_COMPARE = 4'h9;
    localparam logic [3:0] OPC_BIT = 4'hB;
    localparam logic [3:0] OPC_DOUBLE_MIN = 4'h4;

    // Cycle figures (MCLK periods) and word lengths
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;
    localparam logic [3:0] CYC_5 = 4'h5;
    localparam logic [3:0] CYC_6 = 4'h6;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
endpackage

// ==== logic/cycle_decode_if.sv ====
// Interface: operand mode request from decoder to the mode classifier
`timescale 1ns/1ps
interface cycle_decode_if;
    logic [1:0] as_bits;
    logic [3:0] reg_num;
    logic is_dest;
    cycle_decode_pkg::addr_mode_e mode;

    modport decoder (output as_bits, output reg_num, output is_dest, input mode);
    modport classifier (input as_bits, input reg_num, input is_dest, output mode);
endinterface

// ==== logic/addr_mode_classify.sv ====
// Module: maps As/Ad bits and register number to an addressing mode
`timescale 1ns/1ps
module addr_mode_classify (
    cycle_decode_if.classifier mif
);
    // ==========================================
    // Mode classification
    // Constant generator registers count as register mode (no memory fetch)
    always_comb begin
        mif.mode = cycle_decode_pkg::AM_REG;
        if (mif.is_dest) begin
            if (mif.as_bits[0] == 1'b0) begin
                mif.mode = cycle_decode_pkg::AM_REG;
            end else if (mif.reg_num == cycle_decode_pkg::REG_PC) begin
                mif.mode = cycle_decode_pkg::AM_SYMBOLIC;
            end else if (mif.reg_num == cycle_decode_pkg::REG_SR) begin
                mif.mode = cycle_decode_pkg::AM_ABSOLUTE;
            end else begin
                mif.mode = cycle_decode_pkg::AM_INDEXED;
            end
        end else if (mif.reg_num == cycle_decode_pkg::REG_CG) begin
            mif.mode = cycle_decode_pkg::AM_REG;
        end else if (mif.reg_num == cycle_decode_pkg::REG_SR &&
                     mif.as_bits[1]) begin
            mif.mode = cycle_decode_pkg::AM_REG;
        end else begin
            case (mif.as_bits)
                cycle_decode_pkg::AS_REG: mif.mode = cycle_decode_pkg::AM_REG;
                cycle_decode_pkg::AS_IND: mif.mode = cycle_decode_pkg::AM_IND;
                cycle_decode_pkg::AS_INC: begin
                    mif.mode = (mif.reg_num == cycle_decode_pkg::REG_PC) ?
                        cycle_decode_pkg::AM_IMM : cycle_decode_pkg::AM_AUTOINC;
                end
                default: begin
                    if (mif.reg_num == cycle_decode_pkg::REG_PC) begin
                        mif.mode = cycle_decode_pkg::AM_SYMBOLIC;
                    end else if (mif.reg_num == cycle_decode_pkg::REG_SR) begin
                        mif.mode = cycle_decode_pkg::AM_ABSOLUTE;
                    end else begin
                        mif.mode = cycle_decode_pkg::AM_INDEXED;
                    end
                end
            endcase
        end
    end
endmodule

// ==== logic/repeat_counter.sv ====
// Module: repetition counter for prefixed register-mode instructions
`timescale 1ns/1ps
module repeat_counter (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Control
    input wire logic load_in,
    input wire logic [3:0] count_m1_in,
    input wire logic step_in,
    // Status
    output logic busy_out,
    output logic last_out
);
    logic [3:0] remain_r;
    logic busy_r;

    // ==========================================
    // Remaining iterations; holds n-1 and steps down to zero
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            remain_r <= 4'h0;
            busy_r <= 1'b0;
        end else if (load_in) begin
            remain_r <= count_m1_in;
            busy_r <= 1'b1;
        end else if (step_in && busy_r) begin
            if (remain_r == 4'h0) begin
                busy_r <= 1'b0;
            end else begin
                remain_r <= remain_r - 4'h1;
            end
        end
    end

    assign busy_out = busy_r;
    assign last_out = busy_r && (remain_r == 4'h0);
endmodule

// ==== logic/cycle_timing_decoder.sv ====
// Top: cycle count, word length and extension word decode for a 16-bit CPU
// Operation
// - Rotate, swap, sign-extend: 1 cycle register, 3 indirect/autoinc, 4 indexed/symbolic/absolute.
// - Push: 3 cycles short forms, 4 indexed forms; immediate/indexed forms are 2 words.
// - Call: 4 cycles short forms, 5 indexed or symbolic, 6 absolute.
// - Every jump is one word and takes two cycles, taken or not.
// - Register source: 1 to register, 3 to PC, 4 to memory; memory 2 words.
// - Indirect source: 2 to register, 4 to PC, 5 to memory; memory 2 words.
// - Immediate source: 2, 3, 5 cycles; lengths 2, 2, 3 words.
// - Indexed-type source: 3, 5, 6 cycles; lengths 2, 2, 3 words.
// - Move, bit-test, compare take one cycle less to memory destinations.
// - After an extension word, addresses, indexes and immediates are 20 bits.
// - Words 1800h through 1FFFh, opcode bits 15:11, are extension words.
// - Register-mode extension format only for all-register operands; otherwise other format.
// - Some extended instructions need no prefix; decoder does not expect one.
// - Carry-zeroing bit 1 forces carry in 0 in register format; 0 uses current carry.
// - Repeat-source bit 1: bits 3:0 select register whose low nibble is count minus one.
// - Size from length bit and byte bit: 01=20, 10=16, 11=8, 00 reserved.
// - Cycle counts are master clock periods, set by format and modes, and by the opcode for move, bit-test and compare.
`timescale 1ns/1ps
module cycle_timing_decoder (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Fetched code word
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    // Register file reads: repeat count nibble and carry flag
    input wire logic [3:0] rep_reg_nibble_in,
    input wire logic carry_flag_in,
    // Execute handshake
    input wire logic iter_done_in,
    // Decode results
    output logic [3:0] cycles_out,
    output logic [1:0] length_out,
    output logic decode_valid_out,
    output logic ext_pending_out,
    output logic ext_reg_format_out,
    output logic addr20_out,
    output cycle_decode_pkg::op_size_e size_out,
    output logic illegal_size_out,
    output logic carry_in_out,
    output logic [3:0] rep_reg_sel_out,
    output logic rep_from_reg_out,
    output logic [3:0] rep_count_m1_out,
    output logic repeat_busy_out,
    output logic fetch_hold_out
);
    // ==========================================
    // Extension word capture
    logic ext_valid_r;
    logic [15:0] ext_word_r;
    logic is_ext_word;

    // Extension prefix is opcode 00011 in bits 15:11
    assign is_ext_word = (word_in[cycle_decode_pkg::EXT_OP_HI:cycle_decode_pkg::EXT_OP_LO]
                          == cycle_decode_pkg::EXT_OPCODE);

    // Prefix holds until the instruction it modifies arrives
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ext_valid_r <= 1'b0;
            ext_word_r <= 16'h0000;
        end else if (word_valid_in && !fetch_hold_out) begin
            if (is_ext_word) begin
                ext_valid_r <= 1'b1;
                ext_word_r <= word_in;
            end else begin
                ext_valid_r <= 1'b0; // no prefix -> plain decode
            end
        end
    end

    // ==========================================
    // Field extraction from the instruction word
    logic [3:0] opc_hi;
    logic [1:0] as_bits;
    logic ad_bit;
    logic bw_bit;
    logic [3:0] sreg;
    logic [3:0] dreg;
    cycle_decode_pkg::instr_class_e iclass;

    assign opc_hi = word_in[15:12];
    assign as_bits = word_in[cycle_decode_pkg::AS_HI:cycle_decode_pkg::AS_LO];
    assign ad_bit = word_in[cycle_decode_pkg::AD_BIT];
    assign bw_bit = word_in[cycle_decode_pkg::BW_BIT];
    assign sreg = word_in[cycle_decode_pkg::SREG_HI:cycle_decode_pkg::SREG_LO];
    assign dreg = word_in[cycle_decode_pkg::DREG_HI:cycle_decode_pkg::DREG_LO];

    // Class decode; single-operand regs sit in bits 3:0
    always_comb begin
        if (is_ext_word) begin
            iclass = cycle_decode_pkg::IC_EXT_WORD;
        end else if (word_in[15:13] == cycle_decode_pkg::JUMP_PREFIX) begin
            iclass = cycle_decode_pkg::IC_JUMP;
        end else if (opc_hi >= cycle_decode_pkg::OPC_DOUBLE_MIN) begin
            iclass = cycle_decode_pkg::IC_DOUBLE;
        end else if (word_in[15:10] == cycle_decode_pkg::SINGLE_PREFIX) begin
            if (word_in[9:7] == cycle_decode_pkg::OP2_PUSH) begin
                iclass = cycle_decode_pkg::IC_PUSH;
            end else if (word_in[9:7] == cycle_decode_pkg::OP2_CALL) begin
                iclass = cycle_decode_pkg::IC_CALL;
            end else if (word_in[9] == 1'b0) begin
                iclass = cycle_decode_pkg::IC_SINGLE;
            end else begin
                iclass = cycle_decode_pkg::IC_OTHER;
            end
        end else begin
            iclass = cycle_decode_pkg::IC_OTHER;
        end
    end

    // ==========================================
    // Addressing mode classification, source and destination
    cycle_decode_if src_if ();
    cycle_decode_if dst_if ();

    // Single-operand forms carry their operand in the source mode fields
    assign src_if.as_bits = as_bits;
    assign src_if.reg_num = (iclass == cycle_decode_pkg::IC_DOUBLE) ? sreg : dreg;
    assign src_if.is_dest = 1'b0;
    assign dst_if.as_bits = {1'b0, ad_bit};
    assign dst_if.reg_num = dreg;
    assign dst_if.is_dest = 1'b1;

    addr_mode_classify u_src_mode (
        .mif (src_if.classifier)
    );
    addr_mode_classify u_dst_mode (
        .mif (dst_if.classifier)
    );

    // ==========================================
    // Cycle and length table; depends on modes, and on the operation only for move, compare and bit-test
    logic [3:0] cyc_nxt;
    logic [1:0] len_nxt;
    logic dst_mem;
    logic dst_pc;
    logic fewer_op;
    cycle_decode_pkg::addr_mode_e sm;

    assign sm = src_if.mode;
    assign dst_mem = (dst_if.mode != cycle_decode_pkg::AM_REG);
    assign dst_pc = !dst_mem && (dreg == cycle_decode_pkg::REG_PC);
    assign fewer_op = (opc_hi == cycle_decode_pkg::OPC_MOV) ||
                      (opc_hi == cycle_decode_pkg::OPC_COMPARE) ||
                      (opc_hi == cycle_decode_pkg::OPC_BIT);

    always_comb begin
        cyc_nxt = cycle_decode_pkg::CYC_1;
        len_nxt = cycle_decode_pkg::LEN_1;
        case (iclass)
            cycle_decode_pkg::IC_SINGLE: begin
                if (sm == cycle_decode_pkg::AM_REG) begin
                    cyc_nxt = cycle_decode_pkg::CYC_1;
                end else if (sm == cycle_decode_pkg::AM_IND ||
                             sm == cycle_decode_pkg::AM_AUTOINC ||
                             sm == cycle_decode_pkg::AM_IMM) begin
                    cyc_nxt = cycle_decode_pkg::CYC_3;
                end else begin
                    cyc_nxt = cycle_decode_pkg::CYC_4;
                    len_nxt = cycle_decode_pkg::LEN_2;
                end
            end
            cycle_decode_pkg::IC_PUSH: begin
                if (sm == cycle_decode_pkg::AM_INDEXED || sm == cycle_decode_pkg::AM_SYMBOLIC ||
                    sm == cycle_decode_pkg::AM_ABSOLUTE) begin
                    cyc_nxt = cycle_decode_pkg::CYC_4;
                    len_nxt = cycle_decode_pkg::LEN_2;
                end else begin
                    cyc_nxt = cycle_decode_pkg::CYC_3;
                    len_nxt = (sm == cycle_decode_pkg::AM_IMM) ?
                        cycle_decode_pkg::LEN_2 : cycle_decode_pkg::LEN_1;
                end
            end
            cycle_decode_pkg::IC_CALL: begin
                if (sm == cycle_decode_pkg::AM_ABSOLUTE) begin
                    cyc_nxt = cycle_decode_pkg::CYC_6;
                    len_nxt = cycle_decode_pkg::LEN_2;
                end else if (sm == cycle_decode_pkg::AM_INDEXED ||
                             sm == cycle_decode_pkg::AM_SYMBOLIC) begin
                    cyc_nxt = cycle_decode_pkg::CYC_5;
                    len_nxt = cycle_decode_pkg::LEN_2;
                end else begin
                    cyc_nxt = cycle_decode_pkg::CYC_4;
                    len_nxt = (sm == cycle_decode_pkg::AM_IMM) ?
                        cycle_decode_pkg::LEN_2 : cycle_decode_pkg::LEN_1;
                end
            end
            cycle_decode_pkg::IC_JUMP: begin
                cyc_nxt = cycle_decode_pkg::CYC_2;
                len_nxt = cycle_decode_pkg::LEN_1;
            end
            cycle_decode_pkg::IC_DOUBLE: begin
                if (sm == cycle_decode_pkg::AM_REG) begin
                    cyc_nxt = dst_mem ? cycle_decode_pkg::CYC_4 :
                              dst_pc ? cycle_decode_pkg::CYC_3 :
                              cycle_decode_pkg::CYC_1;
                    len_nxt = dst_mem ? cycle_decode_pkg::LEN_2 : cycle_decode_pkg::LEN_1;
                end else if (sm == cycle_decode_pkg::AM_IND ||
                             sm == cycle_decode_pkg::AM_AUTOINC) begin
                    cyc_nxt = dst_mem ? cycle_decode_pkg::CYC_5 :
                              dst_pc ? cycle_decode_pkg::CYC_4 :
                              cycle_decode_pkg::CYC_2;
                    len_nxt = dst_mem ? cycle_decode_pkg::LEN_2 : cycle_decode_pkg::LEN_1;
                end else if (sm == cycle_decode_pkg::AM_IMM) begin
                    cyc_nxt = dst_mem ? cycle_decode_pkg::CYC_5 :
                              dst_pc ? cycle_decode_pkg::CYC_3 :
                              cycle_decode_pkg::CYC_2;
                    len_nxt = dst_mem ? cycle_decode_pkg::LEN_3 : cycle_decode_pkg::LEN_2;
                end else begin
                    cyc_nxt = dst_mem ? cycle_decode_pkg::CYC_6 :
                              dst_pc ? cycle_decode_pkg::CYC_5 :
                              cycle_decode_pkg::CYC_3;
                    len_nxt = dst_mem ? cycle_decode_pkg::LEN_3 : cycle_decode_pkg::LEN_2;
                end
                // One cycle saved: no destination write-back or read
                if (dst_mem && fewer_op) begin
                    cyc_nxt = cyc_nxt - cycle_decode_pkg::CYC_1;
                end
            end
            default: begin
                cyc_nxt = cycle_decode_pkg::CYC_1;
                len_nxt = cycle_decode_pkg::LEN_1;
            end
        endcase
    end

    // ==========================================
    // Extension word interpretation for the prefixed instruction
    logic reg_fmt;
    logic prefixed;
    cycle_decode_pkg::op_size_e size_nxt;

    assign prefixed = ext_valid_r && (iclass != cycle_decode_pkg::IC_EXT_WORD);
    // Register format: both operands register, or single operand register
    assign reg_fmt = (iclass == cycle_decode_pkg::IC_DOUBLE) ?
                     (sm == cycle_decode_pkg::AM_REG && !dst_mem) :
                     (sm == cycle_decode_pkg::AM_REG);

    // Size decode; reserved bits 10:9 and 5:4 are never looked at
    always_comb begin
        case ({ext_word_r[cycle_decode_pkg::EXT_AL_BIT], bw_bit})
            2'b01: size_nxt = cycle_decode_pkg::SZ_ADDR20;
            2'b10: size_nxt = cycle_decode_pkg::SZ_WORD16;
            2'b11: size_nxt = cycle_decode_pkg::SZ_BYTE8;
            default: size_nxt = cycle_decode_pkg::SZ_RESERVED;
        endcase
    end

    // ==========================================
    // Repetition control
    logic rep_load;
    logic rep_busy;
    logic rep_last;
    logic rep_src;
    logic [3:0] rep_m1;

    assign rep_src = ext_word_r[cycle_decode_pkg::EXT_REP_BIT];
    // Register nibble is supplied combinationally by the register file
    assign rep_m1 = rep_src ? rep_reg_nibble_in :
                    ext_word_r[cycle_decode_pkg::EXT_CNT_HI:0];
    assign rep_load = word_valid_in && !fetch_hold_out && prefixed && reg_fmt &&
                      (size_nxt != cycle_decode_pkg::SZ_RESERVED);

    repeat_counter u_rep (
        .core_clk_in (core_clk_in),
        .rst_in (rst_in),
        .load_in (rep_load),
        .count_m1_in (rep_m1),
        .step_in (iter_done_in),
        .busy_out (rep_busy),
        .last_out (rep_last)
    );

    // Fetch waits until every iteration has completed
    assign fetch_hold_out = rep_busy;
    assign repeat_busy_out = rep_busy;
    assign rep_reg_sel_out = ext_word_r[cycle_decode_pkg::EXT_CNT_HI:0];

    // ==========================================
    // Registered decode results
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cycles_out <= 4'h0;
            length_out <= 2'h0;
            decode_valid_out <= 1'b0;
            ext_reg_format_out <= 1'b0;
            addr20_out <= 1'b0;
            size_out <= cycle_decode_pkg::SZ_WORD16;
            illegal_size_out <= 1'b0;
            carry_in_out <= 1'b0;
            rep_from_reg_out <= 1'b0;
            rep_count_m1_out <= 4'h0;
        end else begin
            decode_valid_out <= word_valid_in && !fetch_hold_out &&
                                (iclass != cycle_decode_pkg::IC_EXT_WORD);
            if (word_valid_in && !fetch_hold_out &&
                iclass != cycle_decode_pkg::IC_EXT_WORD) begin
                cycles_out <= cyc_nxt;
                length_out <= len_nxt;
                addr20_out <= prefixed;
                ext_reg_format_out <= prefixed && reg_fmt;
                size_out <= prefixed ? size_nxt :
                            (bw_bit ? cycle_decode_pkg::SZ_BYTE8 : cycle_decode_pkg::SZ_WORD16);
                illegal_size_out <= prefixed &&
                                    (size_nxt == cycle_decode_pkg::SZ_RESERVED);
                // Zeroed carry only applies in register format
                carry_in_out <= (prefixed && reg_fmt &&
                                 ext_word_r[cycle_decode_pkg::EXT_CARRY_ZERO_BIT]) ? 1'b0 :
                                carry_flag_in;
                rep_from_reg_out <= prefixed && reg_fmt && rep_src;
                rep_count_m1_out <= (prefixed && reg_fmt) ? rep_m1 : 4'h0;
            end
        end
    end

    assign ext_pending_out = ext_valid_r;

    // ==========================================
    // Checks
    property p_jump_two;
        @(posedge core_clk_in) disable iff (rst_in)
        (word_valid_in && !fetch_hold_out && word_in[15:13] == cycle_decode_pkg::JUMP_PREFIX)
        |=> (cycles_out == cycle_decode_pkg::CYC_2 && length_out == cycle_decode_pkg::LEN_1);
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump timing wrong");

    property p_ext_prefix;
        @(posedge core_clk_in) disable iff (rst_in)
        (word_valid_in && !fetch_hold_out &&
         word_in[cycle_decode_pkg::EXT_OP_HI:cycle_decode_pkg::EXT_OP_LO] ==
         cycle_decode_pkg::EXT_OPCODE) |=> ext_valid_r;
    endproperty
    a_ext_prefix: assert property (p_ext_prefix) else $error("prefix missed");

    property p_hold_busy;
        @(posedge core_clk_in) disable iff (rst_in)
        rep_load |=> (fetch_hold_out && repeat_busy_out);
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("no hold on repeat");

    property p_cycle_range;
        @(posedge core_clk_in) disable iff (rst_in)
        decode_valid_out |->
            (cycles_out >= cycle_decode_pkg::CYC_1 && cycles_out <= cycle_decode_pkg::CYC_6);
    endproperty
    a_cycle_range: assert property (p_cycle_range) else $error("cycles out of range");

    property p_prefix_wide;
        @(posedge core_clk_in) disable iff (rst_in)
        (word_valid_in && !fetch_hold_out && prefixed) |=> addr20_out;
    endproperty
    a_prefix_wide: assert property (p_prefix_wide) else $error("prefix not widened");

    property p_zero_carry;
        @(posedge core_clk_in) disable iff (rst_in)
        (word_valid_in && !fetch_hold_out && prefixed && reg_fmt &&
         ext_word_r[cycle_decode_pkg::EXT_CARRY_ZERO_BIT]) |=> !carry_in_out;
    endproperty
    a_zero_carry: assert property (p_zero_carry) else $error("carry not zeroed");
endmodule

// ==== tb/operand_bus_model.sv ====
// Model: register nibble read and execute stepping
`timescale 1ns/1ps
module operand_bus_model (
    // Clock and pace
    input wire logic core_clk_in,
    input wire logic slow_in,
    // Decoder side
    input wire logic [3:0] reg_sel_in,
    input wire logic busy_in,
    output logic [3:0] nibble_out,
    output logic done_out
);
    // Fixed pattern per register
    assign nibble_out = reg_sel_in ^ 4'hA;
    // Slow pace leaves gaps, so the hold must last
    always_ff @(posedge core_clk_in) begin
        done_out <= busy_in & (~slow_in | ~done_out);
    end
endmodule

// ==== tb/tb_cpu_cycle_timing_ext_word_decode.sv ====
// Testbench: cycle, length and extension word decode
`timescale 1ns/1ps
module tb_cpu_cycle_timing_ext_word_decode;
    logic core_clk_in, rst_in, word_valid_in, carry_flag_in, iter_done_in, slow;
    logic [15:0] word_in;
    logic [3:0] rep_reg_nibble_in, cycles_out, rep_reg_sel_out, rep_count_m1_out;
    logic [1:0] length_out;
    logic decode_valid_out, ext_pending_out, ext_reg_format_out, addr20_out, illegal_size_out;
    logic carry_in_out, rep_from_reg_out, repeat_busy_out, fetch_hold_out;
    cycle_decode_pkg::op_size_e size_out;
    int fail_count = 0, samples_checked = 0, ticks = 0, steps = 0;
    cycle_timing_decoder dut_u (.core_clk_in, .rst_in, .word_valid_in, .word_in,
        .rep_reg_nibble_in, .carry_flag_in, .iter_done_in, .cycles_out, .length_out,
        .decode_valid_out, .ext_pending_out, .ext_reg_format_out, .addr20_out, .size_out,
        .illegal_size_out, .carry_in_out, .rep_reg_sel_out, .rep_from_reg_out,
        .rep_count_m1_out, .repeat_busy_out, .fetch_hold_out);
    operand_bus_model bus_u (.core_clk_in, .slow_in(slow), .reg_sel_in(rep_reg_sel_out),
        .busy_in(repeat_busy_out), .nibble_out(rep_reg_nibble_in), .done_out(iter_done_in));
    // ====
    // Clock, step count and hang limit
    initial begin
        core_clk_in = 0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        ticks++;
        if (iter_done_in === 1'b1 && repeat_busy_out === 1'b1) steps++;
        if (ticks == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w);
        word_in = w;
        word_valid_in = 1;
        @(posedge core_clk_in);
        #1;
    endtask
    // Prefix and instruction go back to back
    task automatic dec(input logic [15:0] pre, input logic [15:0] w);
        if (pre != 16'h0000) begin
            send(pre);
            chk({3'h0, ext_pending_out}, 4'h1);
        end
        steps = 0;
        send(w);
        word_valid_in = 0;
        chk({3'h0, decode_valid_out}, 4'h1);
        @(posedge core_clk_in);
        #1;
    endtask
    task automatic tm(input logic [15:0] w, input logic [3:0] c, input logic [1:0] l);
        dec(16'h0000, w);
        chk(cycles_out, c);
        chk({2'h0, length_out}, {2'h0, l});
    endtask
    task automatic drain(input logic [3:0] n);
        repeat (100) if (repeat_busy_out === 1'b1) begin
            @(posedge core_clk_in);
            #1;
        end
        chk(steps[3:0], n);
    endtask
    task automatic t_formats();
        tm(16'h1105, 4'h1, 2'h1);
        tm(16'h11A9, 4'h3, 2'h1);
        tm(16'h1012, 4'h4, 2'h2);
        tm(16'h1230, 4'h3, 2'h2);
        tm(16'h1212, 4'h4, 2'h2);
        tm(16'h1284, 4'h4, 2'h1);
        tm(16'h1297, 4'h5, 2'h2);
        tm(16'h1292, 4'h6, 2'h2);
        tm(16'h3C00, 4'h2, 2'h1);
        tm(16'h5500, 4'h3, 2'h1);
        tm(16'h5586, 4'h4, 2'h2);
        tm(16'h4586, 4'h3, 2'h2);
        tm(16'h54B6, 4'h5, 2'h2);
        tm(16'h50B6, 4'h5, 2'h3);
        tm(16'h90B6, 4'h4, 2'h3);
        tm(16'h5210, 4'h5, 2'h2);
        tm(16'hB596, 4'h5, 2'h3);
        $display("formats done");
    endtask
    task automatic t_ext();
        dec(16'h1840, 16'h4A08);
        chk({3'h0, addr20_out}, 4'h1);
        chk({3'h0, ext_reg_format_out}, 4'h1);
        drain(4'h1);
        dec(16'h1800, 16'h5948);
        chk({2'h0, size_out}, 4'h1);
        drain(4'h1);
        dec(16'h1800, 16'h5908);
        chk({illegal_size_out, repeat_busy_out, 2'h0}, 4'h8);
        dec(16'h1840, 16'h5586);
        chk({3'h0, ext_reg_format_out}, 4'h0);
        tm(16'h5508, 4'h1, 2'h1);
        chk({3'h0, addr20_out}, 4'h0);
        $display("ext done");
    endtask
    task automatic t_repeat();
        carry_flag_in = 1;
        dec(16'h1843, 16'h5948);
        chk({carry_in_out, 3'h0}, 4'h8);
        chk(rep_count_m1_out, 4'h3);
        drain(4'h4);
        slow = 1;
        dec(16'h1FFF, 16'h4A08);
        chk({carry_in_out, rep_from_reg_out, 2'h0}, 4'h4);
        chk(rep_reg_sel_out, 4'hF);
        send(16'h3C00);
        word_valid_in = 0;
        chk({ext_pending_out, fetch_hold_out, 1'b0, decode_valid_out}, 4'h4);
        drain(4'h6);
        $display("repeat done");
    endtask
    initial begin
        rst_in = 1;
        word_valid_in = 0;
        word_in = 16'h0000;
        carry_flag_in = 0;
        slow = 0;
        repeat (2) @(posedge core_clk_in);
        #1;
        rst_in = 0;
        t_formats();
        t_ext();
        t_repeat();
        complete_run();
    end
endmodule
